/* File: rtl/link_regs_pkg.sv */
// link_regs_pkg: offsets, field positions, reset values and codes of the
// debug link register set; shared by the register file and its helpers.
package link_regs_pkg;

  // register offsets
  localparam logic [3:0] OFF_INFO   = 4'h0;
  localparam logic [3:0] OFF_ERROR  = 4'h1;
  localparam logic [3:0] OFF_CTRL1  = 4'h2;
  localparam logic [3:0] OFF_CTRL2  = 4'h3;
  localparam logic [3:0] OFF_KEYS   = 4'h7;
  localparam logic [3:0] OFF_RESET_SIGNATURE = 4'h8;
  localparam logic [3:0] OFF_CLKCFG = 4'h9;
  localparam logic [3:0] OFF_SYSCTL = 4'ha;
  localparam logic [3:0] OFF_SYSST  = 4'hb;
  localparam logic [3:0] OFF_CRCST  = 4'hc;

  // field positions
  localparam int BIT_GAP_EN     = 7;
  localparam int BIT_PARITY_OFF = 5;
  localparam int BIT_TIMEOUT_OFF= 4;
  localparam int BIT_RESP_OFF   = 3;
  localparam int BIT_NACK_OFF   = 4;
  localparam int BIT_COLL_OFF   = 3;
  localparam int BIT_LINK_OFF   = 2;
  localparam int BIT_UROW_KEY   = 5;
  localparam int BIT_PROG_KEY   = 4;
  localparam int BIT_ERASE_KEY  = 3;
  localparam int BIT_UROW_DONE  = 1;
  localparam int BIT_CLK_HOLD   = 0;

  // writable masks and reset values
  localparam logic [7:0] CTRL1_MASK   = 8'hbf;
  localparam logic [7:0] CTRL2_MASK   = 8'h1c;
  localparam logic [7:0] CTRL1_RESET  = 8'h00;
  localparam logic [7:0] CTRL2_RESET  = 8'h00;
  localparam logic [1:0] CLKSEL_RESET = 2'h3;
  localparam logic [7:0] RESET_SIG    = 8'h59;

  // error signature codes
  localparam logic [2:0] ERR_NONE     = 3'h0;
  localparam logic [2:0] ERR_PARITY   = 3'h1;
  localparam logic [2:0] ERR_FRAME    = 3'h2;
  localparam logic [2:0] ERR_TIMEOUT  = 3'h3;
  localparam logic [2:0] ERR_CLKREC   = 3'h4;
  localparam logic [2:0] ERR_BUS      = 3'h6;
  localparam logic [2:0] ERR_CONTEND  = 3'h7;

  // guard time: code 0..6 gives 128 >> code link cycles
  localparam logic [7:0] GUARD_MAX    = 8'h80;
  localparam logic [2:0] GUARD_RSVD   = 3'h7;

  // bus-side time-out in link clock cycles
  localparam int TIMEOUT_CYCLES = 65536;

  // link clock select codes, frequencies in MHz
  localparam logic [1:0] CLKSEL_16 = 2'h1;
  localparam logic [1:0] CLKSEL_8  = 2'h2;
  localparam logic [1:0] CLKSEL_4  = 2'h3;
  localparam int REF_MHZ = 50;

  // register access carried from the link instruction decoder
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_access_s;

  // framing and layer error events from the link layer
  typedef struct packed {
    logic parity;
    logic frame;
    logic clkrec;
    logic bus;
    logic contend;
  } link_err_s;

endpackage : link_regs_pkg

/* File: rtl/link_guard_timer.sv */
// link_guard_timer: guard wait on turnaround from receive to transmit.
// assumes turn_start is a one-cycle pulse and bit_tick the link clock enable.
`timescale 1ns/1ps
module link_guard_timer
  import link_regs_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       bit_tick,
  input  wire logic [2:0] guard_code,
  input  wire logic       turn_start,
  // status
  output logic            guard_busy
);

  logic [7:0] count_reg;

  // reserved code falls back to the longest wait, the safe side
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_reg  <= 8'h00;
      guard_busy <= 1'b0;
    end else if (turn_start) begin
      count_reg  <= (guard_code == GUARD_RSVD) ? GUARD_MAX : (GUARD_MAX >> guard_code);
      guard_busy <= 1'b1;
    end else if (guard_busy && bit_tick) begin
      count_reg  <= count_reg - 8'h01;
      guard_busy <= (count_reg != 8'h01);
    end
  end

endmodule // link_guard_timer

/* File: rtl/link_timeout.sv */
// link_timeout: waits for the bus-side layer to answer a request.
// assumes req_start pulses once per request and resp_seen ends the wait.
`timescale 1ns/1ps
module link_timeout
  import link_regs_pkg::*;
#(
  parameter int LIMIT = TIMEOUT_CYCLES
)(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // control
  input  wire logic bit_tick,
  input  wire logic check_off,
  input  wire logic req_start,
  input  wire logic resp_seen,
  // event
  output logic      timed_out
);

  logic [16:0] count_reg;
  logic        wait_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_reg <= 17'h00000;
      wait_reg  <= 1'b0;
      timed_out <= 1'b0;
    end else begin
      timed_out <= 1'b0;
      if (req_start) begin
        count_reg <= 17'h00000;
        wait_reg  <= 1'b1;
      end else if (resp_seen) begin
        wait_reg <= 1'b0;
      end else if (wait_reg && bit_tick) begin
        count_reg <= count_reg + 17'h00001;
        if (count_reg == 17'(LIMIT - 1)) begin
          wait_reg  <= 1'b0;
          timed_out <= !check_off;
        end
      end
    end
  end

endmodule // link_timeout

/* File: rtl/link_ctrl_regs.sv */
// link_ctrl_regs: control and status registers of the single-wire debug
// link, reached only through register instructions of the link decoder.
// assumes the decoder, link layer and system status arrive synchronous
// to ref_clk; the core has no path into this block.
//
// Overview of operation
// - only the debugger reaches these registers
// - revision code in info register upper nibble
// - error code loads on error, clears on read
// - parity 1, stop bits 2, start bit 4
// - timeout 3, bus 6, contention 7
// - gap enable adds two idle bits
// - parity off ignores received parity bit
// - no bus answer in 65536 cycles: timeout
// - response signatures off when bit set
// - turnaround guard 128 down to 2 cycles
// - no reset nack when bit set
// - collision check runs unless bit set
// - link off resets config, keys, clock hold
// - user row key set on decode, written last
// - program key set, cleared when programming starts
// - erase key cleared by erase reset request
// - 0x59 holds system reset, else released
// - system reset leaves link logic running
// - clock select 16, 8, 4 MHz, default 4
// - clock hold set by full reset, cleared by link off
`timescale 1ns/1ps
module link_ctrl_regs
  import link_regs_pkg::*;
#(
  parameter logic [3:0] LINK_REVISION = 4'h3,  // arbitrary value
  parameter int         TIMEOUT_LEN   = TIMEOUT_CYCLES
)(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // register access from the link instruction decoder
  input  wire reg_access_s acc,
  output logic [7:0]       rdata,
  output logic             rvalid,
  // link layer events
  input  wire logic        bit_tick,
  input  wire link_err_s   err_in,
  input  wire logic        bus_req_start,
  input  wire logic        bus_resp_seen,
  input  wire logic        turn_start,
  input  wire logic        sys_reset_seen,
  // key decoder
  input  wire logic        erase_key_seen,
  input  wire logic        prog_key_seen,
  input  wire logic        urow_key_seen,
  // system status
  input  wire logic        sys_prog_ready,
  input  wire logic [7:0]  sys_status,
  input  wire logic [7:0]  crc_status,
  // link layer configuration
  output logic             gap_en,
  output logic             parity_check_off,
  output logic             resp_sig_off,
  output logic             neg_ack_off,
  output logic             collision_check_off,
  output logic             guard_busy,
  output logic             send_nack,
  output logic             link_enabled,
  output logic [1:0]       link_clock_sel,
  output logic [3:0]       clk_div,
  // system side
  output logic             system_in_reset,
  output logic             sys_clock_hold,
  output logic             user_row_done
);

  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [2:0] err_reg;
  logic [2:0] err_next;
  logic       urow_key_reg;
  logic       prog_key_reg;
  logic       erase_key_reg;
  logic [7:0] reset_signature_reg;
  logic       timed_out;
  logic       link_rst_n;
  logic       wr_info;
  logic       rd_err;

  // link off acts as a link-only reset; system reset never reaches here
  assign link_rst_n = rst_n && !ctrl2_reg[BIT_LINK_OFF];
  assign rd_err     = acc.rd && (acc.addr == OFF_ERROR);
  assign wr_info    = acc.wr;

  // control registers; reserved bits masked off
  always_ff @(posedge ref_clk) begin
    if (!link_rst_n) begin
      ctrl1_reg <= CTRL1_RESET;
    end else if (wr_info && acc.addr == OFF_CTRL1) begin
      ctrl1_reg <= acc.wdata & CTRL1_MASK;
    end
  end

  // link off bit itself survives so the link stays down; only rst_n clears it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl2_reg <= CTRL2_RESET;
    end else if (ctrl2_reg[BIT_LINK_OFF]) begin
      ctrl2_reg <= CTRL2_RESET | (8'h01 << BIT_LINK_OFF);
    end else if (wr_info && acc.addr == OFF_CTRL2) begin
      ctrl2_reg <= acc.wdata & CTRL2_MASK;
    end
  end

  // error signature: new error wins over the clearing read
  always_comb begin
    err_next = err_reg;
    if (rd_err) begin
      err_next = ERR_NONE;
    end
    if (err_in.contend && !ctrl2_reg[BIT_COLL_OFF]) begin
      err_next = ERR_CONTEND;
    end else if (err_in.bus) begin
      err_next = ERR_BUS;
    end else if (timed_out) begin
      err_next = ERR_TIMEOUT;
    end else if (err_in.clkrec) begin
      err_next = ERR_CLKREC;
    end else if (err_in.frame) begin
      err_next = ERR_FRAME;
    end else if (err_in.parity && !ctrl1_reg[BIT_PARITY_OFF]) begin
      err_next = ERR_PARITY;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!link_rst_n) begin
      err_reg <= ERR_NONE;
    end else begin
      err_reg <= err_next;
    end
  end

  // key flags; set wins over every clear
  always_ff @(posedge ref_clk) begin
    if (!link_rst_n) begin
      urow_key_reg  <= 1'b0;
      prog_key_reg  <= 1'b0;
      erase_key_reg <= 1'b0;
    end else begin
      if (urow_key_seen) begin
        urow_key_reg <= 1'b1;
      end else if (wr_info && acc.addr == OFF_KEYS && acc.wdata[BIT_UROW_KEY]) begin
        urow_key_reg <= 1'b0;
      end
      if (prog_key_seen) begin
        prog_key_reg <= 1'b1;
      end else if (sys_prog_ready) begin
        prog_key_reg <= 1'b0;
      end
      if (erase_key_seen) begin
        erase_key_reg <= 1'b1;
      end else if (wr_info && acc.addr == OFF_RESET_SIGNATURE && acc.wdata == RESET_SIG) begin
        erase_key_reg <= 1'b0;
      end
    end
  end

  // reset request: only the exact signature holds the system
  always_ff @(posedge ref_clk) begin
    if (!link_rst_n) begin
      reset_signature_reg      <= 8'h00;
      system_in_reset <= 1'b0;
    end else if (wr_info && acc.addr == OFF_RESET_SIGNATURE) begin
      reset_signature_reg      <= acc.wdata;
      system_in_reset <= (acc.wdata == RESET_SIG);
    end
  end

  // clock select and clock hold
  always_ff @(posedge ref_clk) begin
    if (!link_rst_n) begin
      link_clock_sel <= CLKSEL_RESET;
      // full reset raises the hold, link off drops it
      sys_clock_hold <= !rst_n;
      user_row_done  <= 1'b0;
    end else begin
      user_row_done <= 1'b0;
      if (wr_info && acc.addr == OFF_CLKCFG && acc.wdata[1:0] != 2'h0) begin
        link_clock_sel <= acc.wdata[1:0];
      end
      if (wr_info && acc.addr == OFF_SYSCTL) begin
        sys_clock_hold <= acc.wdata[BIT_CLK_HOLD];
        user_row_done  <= acc.wdata[BIT_UROW_DONE] && urow_key_reg;
      end
    end
  end

  // divider ratio: reference cycles per link clock cycle, rounded down
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      clk_div <= 4'(REF_MHZ / 4);
    end else begin
      case (link_clock_sel)
        CLKSEL_16: clk_div <= 4'(REF_MHZ / 16);
        CLKSEL_8:  clk_div <= 4'(REF_MHZ / 8);
        CLKSEL_4:  clk_div <= 4'(REF_MHZ / 4);
        default:   clk_div <= clk_div;
      endcase
    end
  end

  // configuration outputs registered
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gap_en              <= 1'b0;
      parity_check_off    <= 1'b0;
      resp_sig_off        <= 1'b0;
      neg_ack_off         <= 1'b0;
      collision_check_off <= 1'b0;
      link_enabled        <= 1'b0;
      send_nack           <= 1'b0;
    end else begin
      gap_en              <= ctrl1_reg[BIT_GAP_EN];
      parity_check_off    <= ctrl1_reg[BIT_PARITY_OFF];
      resp_sig_off        <= ctrl1_reg[BIT_RESP_OFF];
      neg_ack_off         <= ctrl2_reg[BIT_NACK_OFF];
      collision_check_off <= ctrl2_reg[BIT_COLL_OFF];
      link_enabled        <= !ctrl2_reg[BIT_LINK_OFF];
      send_nack           <= sys_reset_seen && !ctrl2_reg[BIT_NACK_OFF]
                             && !ctrl1_reg[BIT_RESP_OFF];
    end
  end

  // read mux; unmapped and reserved read as zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= acc.rd;
      if (acc.rd) begin
        case (acc.addr)
          OFF_INFO:   rdata <= {LINK_REVISION, 4'h0};
          OFF_ERROR:  rdata <= {5'h00, err_reg};
          OFF_CTRL1:  rdata <= ctrl1_reg;
          OFF_CTRL2:  rdata <= ctrl2_reg;
          OFF_KEYS:   rdata <= {2'h0, urow_key_reg, prog_key_reg, erase_key_reg, 3'h0};
          OFF_RESET_SIGNATURE: rdata <= reset_signature_reg;
          OFF_CLKCFG: rdata <= {6'h00, link_clock_sel};
          OFF_SYSCTL: rdata <= {7'h00, sys_clock_hold};
          OFF_SYSST:  rdata <= sys_status & 8'h3d;
          OFF_CRCST:  rdata <= {5'h00, crc_status[2:0]};
          default:    rdata <= 8'h00;
        endcase
      end
    end
  end

  link_guard_timer u_guard (
    .ref_clk    (ref_clk),
    .rst_n      (link_rst_n),
    .bit_tick   (bit_tick),
    .guard_code (ctrl1_reg[2:0]),
    .turn_start (turn_start),
    .guard_busy (guard_busy)
  );

  // timeout counts link clock ticks, not reference cycles
  link_timeout #(
    .LIMIT (TIMEOUT_LEN)
  ) u_timeout (
    .ref_clk   (ref_clk),
    .rst_n     (link_rst_n),
    .bit_tick  (bit_tick),
    .check_off (ctrl1_reg[BIT_TIMEOUT_OFF]),
    .req_start (bus_req_start),
    .resp_seen (bus_resp_seen),
    .timed_out (timed_out)
  );

endmodule // link_ctrl_regs

/* File: sim/link_ctrl_regs_sva.sv */
// link_ctrl_regs_sva: port checks of the debug link register block.
// assumes the bench keeps error pulses and pending bus waits away from error reads.
`timescale 1ns/1ps
module link_ctrl_regs_sva
  import link_regs_pkg::*;
#(
  parameter logic [3:0] LINK_REVISION = 4'h3
)(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // watched ports
  input wire reg_access_s acc,
  input wire link_err_s   err_in,
  input wire logic [7:0]  rdata,
  input wire logic        rvalid,
  input wire logic        turn_start,
  input wire logic        guard_busy,
  input wire logic        sys_reset_seen,
  input wire logic        neg_ack_off,
  input wire logic        resp_sig_off,
  input wire logic        send_nack,
  input wire logic        link_enabled,
  input wire logic        sys_clock_hold,
  input wire logic [1:0]  link_clock_sel,
  input wire logic        system_in_reset
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  read_answer_a: assert property (acc.rd |=> rvalid)
    else $error("read not answered");
  read_origin_a: assert property (rvalid |-> $past(acc.rd))
    else $error("answer without read");
  revision_code_a: assert property (acc.rd && acc.addr == OFF_INFO |=> rdata == {LINK_REVISION, 4'h0})
    else $error("bad revision read");
  reserved_zero_a: assert property (acc.rd && acc.addr inside {4'h4, 4'h5, 4'h6} |=> rdata == 8'h00)
    else $error("reserved offset not zero");
  error_clear_a: assert property (acc.rd && acc.addr == OFF_ERROR && err_in == '0 ##1 (err_in == '0) [*2]
    ##0 acc.rd && acc.addr == OFF_ERROR |=> rdata == 8'h00)
    else $error("error code not cleared");
  reset_hold_a: assert property (acc.wr && acc.addr == OFF_RESET_SIGNATURE && acc.wdata == RESET_SIG
    |-> ##[1:2] system_in_reset)
    else $error("reset signature ignored");
  reset_release_a: assert property (acc.wr && acc.addr == OFF_RESET_SIGNATURE && acc.wdata != RESET_SIG
    |-> ##[1:2] !system_in_reset)
    else $error("reset not released");
  link_off_a: assert property (acc.wr && acc.addr == OFF_CTRL2 && acc.wdata[BIT_LINK_OFF]
    |-> ##[1:2] !link_enabled && !sys_clock_hold)
    else $error("link off not applied");
  clksel_keep_a: assert property (acc.wr && acc.addr == OFF_CLKCFG && acc.wdata[1:0] == 2'h0
    |=> $stable(link_clock_sel) [*2])
    else $error("reserved clock code taken");
  guard_start_a: assert property (turn_start && !guard_busy |-> ##[1:2] guard_busy)
    else $error("guard wait not started");
  nack_send_a: assert property (sys_reset_seen && !neg_ack_off && !resp_sig_off
    |-> ##[1:2] send_nack)
    else $error("nack missing");
  nack_quiet_a: assert property (sys_reset_seen && neg_ack_off |=> !send_nack [*2])
    else $error("nack sent while off");
endmodule // link_ctrl_regs_sva

bind link_ctrl_regs link_ctrl_regs_sva #(.LINK_REVISION(LINK_REVISION)) chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .acc(acc), .err_in(err_in), .rdata(rdata),
  .rvalid(rvalid), .turn_start(turn_start), .guard_busy(guard_busy),
  .sys_reset_seen(sys_reset_seen), .neg_ack_off(neg_ack_off), .send_nack(send_nack),
  .resp_sig_off(resp_sig_off),
  .link_enabled(link_enabled), .sys_clock_hold(sys_clock_hold),
  .link_clock_sel(link_clock_sel), .system_in_reset(system_in_reset));

/* File: sim/link_debugger.sv */
// link_debugger: debugger side issuing register instructions.
// assumes one access in flight; slow adds idle cycles before each request.
`timescale 1ns/1ps
module link_debugger
  import link_regs_pkg::*;
(
  // clock
  input  wire logic       ref_clk,
  // register access
  output reg_access_s     acc,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  int unsigned slow = 0;
  logic [7:0]  last_rd;
  logic        rd_ok;

  initial acc = '0;

  task automatic put(input logic w, input logic [3:0] a, input logic [7:0] d);
    repeat (slow + 1) @(posedge ref_clk);
    acc <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge ref_clk);
    // released fields flip so a stale value cannot pass
    acc <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    rd_ok = w;
    for (int i = 0; i < 4 && !rd_ok; i++) begin
      @(negedge ref_clk);
      if (rvalid === 1'b1) begin
        rd_ok = 1'b1;
        last_rd = rdata;
      end
    end
  endtask
endmodule // link_debugger

/* File: sim/tb_link_ctrl_regs.sv */
// tb_link_ctrl_regs: self-checking bench of the debug link register block.
// assumes a bus-side time-out shortened to 16 ticks and a tick every cycle.
`timescale 1ns/1ps
module tb_link_ctrl_regs;
  import link_regs_pkg::*;
  localparam logic [3:0] REV = 4'h3;  // arbitrary value
  localparam int         TOL = 16;
  logic        ref_clk = 0, rst_n = 0, bit_tick = 1, prog_rdy = 0;
  logic [11:0] ev = '0;
  logic [7:0]  sys_st = '0, crc_st = '0, rdata, v;
  reg_access_s acc;
  logic        rvalid, gap_en, par_off, rsp_off, nack_off, coll_off, gbusy, nack;
  logic        lnk_en, in_rst, clk_hold, urd;
  logic [1:0]  csel, exp_sel;
  logic [3:0]  cdiv;
  int          n_fail = 0, compares = 0, n, seed = 32'hc03c3c36;

  link_debugger dbg (.ref_clk(ref_clk), .acc(acc), .rdata(rdata), .rvalid(rvalid));
  link_ctrl_regs #(.LINK_REVISION(REV), .TIMEOUT_LEN(TOL)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .acc(acc), .rdata(rdata), .rvalid(rvalid),
    .bit_tick(bit_tick), .err_in(ev[11:7]), .bus_req_start(ev[0]), .bus_resp_seen(ev[1]),
    .turn_start(ev[2]), .sys_reset_seen(ev[3]), .erase_key_seen(ev[4]),
    .prog_key_seen(ev[5]), .urow_key_seen(ev[6]), .sys_prog_ready(prog_rdy),
    .sys_status(sys_st), .crc_status(crc_st), .gap_en(gap_en), .parity_check_off(par_off),
    .resp_sig_off(rsp_off), .neg_ack_off(nack_off), .collision_check_off(coll_off),
    .guard_busy(gbusy), .send_nack(nack), .link_enabled(lnk_en), .link_clock_sel(csel),
    .clk_div(cdiv), .system_in_reset(in_rst), .sys_clock_hold(clk_hold), .user_row_done(urd));

  initial forever #10 ref_clk = ~ref_clk;

  function automatic logic [2:0] err_code(input int k);
    logic [2:0] t [6] = '{3'h7, 3'h6, 3'h4, 3'h2, 3'h1, 3'h7};
    return t[k];
  endfunction

  function automatic logic [7:0] guard_len(input logic [2:0] c);
    return c == 3'h7 ? 8'h80 : 8'h80 >> c;
  endfunction

  task automatic end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] want, input string what);
    compares++;
    if (got !== want) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] want, input string what);
    dbg.put(1'b0, a, 8'h00);
    check(dbg.rd_ok ? dbg.last_rd : 8'hxx, want, what);
    if (!dbg.rd_ok) end_sim;
  endtask

  task automatic pulse(input logic [11:0] m);
    @(posedge ref_clk) ev <= m;
    @(posedge ref_clk) ev <= '0;
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1;
    for (int a = 0; a < 10; a++) begin
      rd(a[3:0], a == 0 ? {REV, 4'h0} : (a == 9 ? 8'h03 : 8'h00), "reset value");
    end
    check({7'h0, clk_hold}, 8'h01, "clock hold");
    exp_sel = 2'h3;
    for (int i = 0; i < 24; i++) begin
      v = 8'($random(seed));
      if (i < 2) v = i ? 8'h00 : RESET_SIG;
      dbg.slow = i % 3;
      dbg.put(1'b1, OFF_CTRL1, v);
      dbg.put(1'b1, OFF_CTRL2, v & 8'hfb);
      dbg.put(1'b1, OFF_RESET_SIGNATURE, v);
      dbg.put(1'b1, OFF_CLKCFG, v);
      if (v[1:0] != 2'h0) exp_sel = v[1:0];
      sys_st <= v;
      crc_st <= ~v;
      rd(OFF_CTRL1, v & CTRL1_MASK, "control one");
      rd(OFF_CTRL2, v & 8'h18, "control two");
      rd(OFF_RESET_SIGNATURE, v, "reset request");
      rd(OFF_CLKCFG, {6'h0, exp_sel}, "clock select");
      rd(OFF_SYSST, v & 8'h3d, "system state");
      rd(OFF_CRCST, ~v & 8'h07, "checksum state");
      check({gap_en, par_off, rsp_off, nack_off, coll_off, in_rst, csel},
            {v[7], v[5], v[3], v[4], v[3], v == RESET_SIG, exp_sel}, "outputs");
      check({4'h0, cdiv}, 8'(REF_MHZ / (exp_sel == 2'h1 ? 16 : exp_sel == 2'h2 ? 8 : 4)),
            "clock divider");
    end
    dbg.slow = 0;
    dbg.put(1'b1, OFF_CTRL1, 8'h00);
    // collision check must be on for the contention code
    dbg.put(1'b1, OFF_CTRL2, 8'h00);
    for (int k = 0; k < 6; k++) begin
      pulse(k < 5 ? 12'h080 << k : 12'hf80);
      rd(OFF_ERROR, {5'h0, err_code(k)}, "error code");
      rd(OFF_ERROR, 8'h00, "error cleared");
    end
    for (int k = 0; k < 3; k++) begin
      dbg.put(1'b1, OFF_CTRL1, k == 1 ? 8'h10 : 8'h00);
      pulse(12'h001);
      if (k == 2) pulse(12'h002);
      repeat (TOL + 4) @(posedge ref_clk);
      rd(OFF_ERROR, k == 0 ? {5'h0, ERR_TIMEOUT} : 8'h00, "time-out");
    end
    for (int c = 0; c < 8; c++) begin
      dbg.put(1'b1, OFF_CTRL1, c[7:0]);
      pulse(12'h004);
      n = 0;
      for (int t = 0; t < 300 && (n == 0 || gbusy); t++) begin
        @(negedge ref_clk);
        if (gbusy === 1'b1) n++;
      end
      check(n[7:0], guard_len(c[2:0]), "guard time");
    end
    for (int k = 0; k < 2; k++) begin
      dbg.put(1'b1, OFF_CTRL2, {3'h0, k[0], 4'h0});
      repeat (2) @(posedge ref_clk);
      pulse(12'h008);
      v = '0;
      repeat (3) @(negedge ref_clk) v[0] = v[0] | nack;
      check(v, {7'h0, !k[0]}, "nack");
    end
    pulse(12'h070);
    rd(OFF_KEYS, 8'h38, "keys set");
    dbg.put(1'b1, OFF_SYSCTL, 8'h03);
    @(negedge ref_clk) check({7'h0, urd}, 8'h01, "user row done");
    dbg.put(1'b1, OFF_KEYS, 8'h18);
    rd(OFF_KEYS, 8'h38, "keys read-only");
    @(posedge ref_clk) prog_rdy <= 1;
    rd(OFF_KEYS, 8'h28, "program key");
    dbg.put(1'b1, OFF_RESET_SIGNATURE, RESET_SIG);
    rd(OFF_KEYS, 8'h20, "erase key");
    dbg.put(1'b1, OFF_RESET_SIGNATURE, 8'h00);
    dbg.put(1'b1, OFF_KEYS, 8'h20);
    rd(OFF_KEYS, 8'h00, "user row key");
    dbg.put(1'b1, OFF_CTRL1, 8'hbf);
    pulse(12'h040);
    dbg.put(1'b1, OFF_CTRL2, 8'h04);
    rd(OFF_CTRL1, 8'h00, "config after off");
    rd(OFF_KEYS, 8'h00, "keys after off");
    check({6'h0, lnk_en, clk_hold}, 8'h00, "link off");
    @(posedge ref_clk) rst_n <= 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1;
    rd(OFF_CTRL2, 8'h00, "second reset");
    check({5'h0, clk_hold, csel}, 8'h07, "hold and select");
    end_sim;
  end
endmodule // tb_link_ctrl_regs
